/* rtl/cip_regs.svh */
// Constants shared by both ends of the core interrupt and power link.
// Assumes it is included by its bare name from the package and modules.
`ifndef CIP_REGS_SVH
`define CIP_REGS_SVH

// Width of the interrupt request lines and of every priority field.
`define CIP_INT_W        6
// Width of the register shadow set number.
`define CIP_SS_W         4
// Highest vector number an encoded request can carry.
`define CIP_MAX_SRC      63
// Least number of synchroniser stages on a pin input.
`define CIP_SYNC_STAGES  2
// Bit of the written status word that holds the reduced-power bit.
`define CIP_STATUS_RP    27
// Width of the status word that software writes.
`define CIP_STATUS_W     32
// Reset value of every priority and vector field.
`define CIP_PRIO_RST     6'h00
// Reset value of the shadow set number.
`define CIP_SS_RST       4'h0
// Level that the controller drives on the presence strap.
`define CIP_STRAP_ON     1'b1

`endif

/* rtl/cip_pkg.sv */
// Types and the shared priority encoder of the interrupt and power link.
// Assumes cip_regs.svh is on the include path.
`include "cip_regs.svh"

package cip_pkg;

    // Interrupt mode that software selects.
    typedef enum logic [1:0] {
        CIP_MODE_COMPAT = 2'b00,
        CIP_MODE_VECTOR = 2'b01,
        CIP_MODE_EIC    = 2'b10
    } cip_mode_t;

    // Execution state of the core end.
    typedef enum logic [1:0] {
        CIP_ST_RUN     = 2'b00,
        CIP_ST_SLEEP   = 2'b01,
        CIP_ST_HANDLER = 2'b10
    } cip_core_state_t;

    // All state of the core end.
    typedef struct packed {
        cip_core_state_t         st;
        logic                    rp;
        logic                    sleep;
        logic                    ack;
        logic                    taken;
        logic                    busy;
        logic                    cap_eic;
        logic [`CIP_INT_W-1:0]   ipl;
        logic [`CIP_INT_W-1:0]   ripl;
        logic [`CIP_INT_W-1:0]   vector;
        logic [`CIP_SS_W-1:0]    shadow;
    } cip_core_reg_t;

    // All state of the controller end.
    typedef struct packed {
        logic                    strap;
        logic [`CIP_INT_W-1:0]   lines;
        logic [`CIP_INT_W-1:0]   last;
        logic [`CIP_INT_W-1:0]   ipl;
        logic [`CIP_SS_W-1:0]    shadow;
        logic [`CIP_MAX_SRC-1:0] in_service;
    } cip_ctrl_reg_t;

    // Number one above the highest set bit, zero when none is set.
    function automatic logic [`CIP_INT_W-1:0] cip_highest(
        input logic [`CIP_MAX_SRC-1:0] req
    );
        logic [`CIP_INT_W-1:0] res;
        res = `CIP_PRIO_RST;
        for (int i = 0; i < `CIP_MAX_SRC; i++) begin
            if (req[i]) begin
                res = `CIP_INT_W'(i + 1);
            end
        end
        return res;
    endfunction

endpackage

/* rtl/cip_if.sv */
// Link between the processor core end and the interrupt controller end.
// Assumes both ends run on the same core clock; no clocking block.
`timescale 1ns/1ns
`include "cip_regs.svh"

interface cip_if;
    logic [`CIP_INT_W-1:0] int_lines;
    logic [`CIP_SS_W-1:0]  shadow_set_select_in;
    logic                  ext_controller_present_strap;
    logic                  interrupt_ack_pulse;
    logic [`CIP_INT_W-1:0] current_priority_out;
    logic                  reduced_power_hint_out;
    logic                  sleep_ind;

    // Core end: takes requests, drives acknowledge and power hints.
    modport core (
        input  int_lines,
        input  shadow_set_select_in,
        input  ext_controller_present_strap,
        output interrupt_ack_pulse,
        output current_priority_out,
        output reduced_power_hint_out,
        output sleep_ind
    );

    // Controller end: presents requests, watches the acknowledge.
    modport ctrl (
        output int_lines,
        output shadow_set_select_in,
        output ext_controller_present_strap,
        input  interrupt_ack_pulse,
        input  current_priority_out,
        input  reduced_power_hint_out,
        input  sleep_ind
    );
endinterface

/* rtl/cip_sync.sv */
// Multi-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no coherence across bits.
`timescale 1ns/1ns

module cip_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // All state: one row of flip-flops per stage, stage 0 at the pin.
    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] stage;
    } cip_sync_reg_t;

    cip_sync_reg_t r_q;
    cip_sync_reg_t r_d;

    // Refuse a chain too short to settle metastability.
    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("cip_sync needs at least two stages and one bit");
        end
    end

    // Shift one stage per clock.  The first stage feeds only the second,
    // so a metastable level never reaches any other logic.
    always_comb begin
        r_d          = r_q;
        r_d.stage[0] = async_i;
        for (int i = 1; i < STAGES; i++) begin
            r_d.stage[i] = r_q.stage[i-1];
        end
    end

    // One register for the whole chain.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sync_o = r_q.stage[STAGES-1];

endmodule

/* rtl/cip_core_end.sv */
// Core end of the interrupt and power link: request intake, take and
// acknowledge, sleep after the idle-halt instruction, power hint.
// Assumes the controller end shares SYS_CLK_I and the link interface.
//
// Notes on behaviour
// - Hint output mirrors status reduced-power bit.
// - Idle-halt instruction raises sleep indication; here only in the run state, a handler ignores it.
// - Asleep: clock held, waiting for an interrupt.
// - Presence strap readable as capability field.
// - Controller supplies shadow set, used when servicing.
// - Acknowledge lasts one cycle per interrupt taken in encoded mode.
// - Taken interrupt captures lines into priority field.
// - Controller may advance after seeing acknowledge.
// - Lines active high, read per selected mode.
// - Lines synchronised in non-encoded modes.
// - Controller changes encoded lines on core clock.
// - Lines level sensitive, held until serviced.
// - Compatibility mode: equal priority, no vectors.
// - Controller presents 6-bit vector, 0 to 63.
// - Priority output from status, updated at acknowledge.
`timescale 1ns/1ns
`include "cip_regs.svh"

module cip_core_end #(
    parameter int SYNC_STAGES = `CIP_SYNC_STAGES
) (
    // Clock and reset.
    input  wire logic                      SYS_CLK_I,
    input  wire logic                      SRST_I,
    // Link to the interrupt controller.
    cip_if.core                            LINK,
    // Software view of the status register.
    input  wire logic                      STATUS_WE_I,
    input  wire logic [`CIP_STATUS_W-1:0]  STATUS_WDATA_I,
    input  wire logic [`CIP_INT_W-1:0]     STATUS_IPL_I,
    input  wire logic                      INT_ENABLE_I,
    input  wire logic [`CIP_INT_W-1:0]     INT_MASK_I,
    input  wire cip_pkg::cip_mode_t        INT_MODE_I,
    // Pipeline events.
    input  wire logic                      WAIT_EXEC_I,
    input  wire logic                      ERET_I,
    // Results for the pipeline and for software.
    output logic                           INT_TAKEN_O,
    output logic                           IN_HANDLER_O,
    output logic                           SLEEP_O,
    output logic                           CAP_EIC_O,
    output logic [`CIP_INT_W-1:0]          RIPL_O,
    output logic [`CIP_INT_W-1:0]          VECTOR_O,
    output logic [`CIP_SS_W-1:0]           SHADOW_SET_O
);
    import cip_pkg::*;

    cip_core_reg_t         r_q;
    cip_core_reg_t         r_d;
    logic [`CIP_INT_W:0]   pin_sync;
    logic [`CIP_INT_W-1:0] lines_sync;
    logic                  strap_sync;
    logic                  eic_mode;
    logic [`CIP_INT_W-1:0] lines_use;
    logic [`CIP_INT_W-1:0] lines_masked;
    logic                  req_pending;
    logic [`CIP_INT_W-1:0] vec_sel;

    // Refuse a synchroniser too short to be safe.
    initial begin
        if (SYNC_STAGES < `CIP_SYNC_STAGES) begin
            $error("cip_core_end needs at least two sync stages");
        end
    end

    // Request lines and strap arrive from pins, so they are synchronised
    // before logic looks at them, except the lines that encoded mode reads raw.
    cip_sync #(
        .WIDTH  (`CIP_INT_W + 1),
        .STAGES (SYNC_STAGES)
    ) u_pin_sync (
        .clk_i   (SYS_CLK_I),
        .srst_i  (SRST_I),
        .async_i ({LINK.ext_controller_present_strap, LINK.int_lines}),
        .sync_o  (pin_sync)
    );

    assign lines_sync = pin_sync[`CIP_INT_W-1:0];
    assign strap_sync = pin_sync[`CIP_INT_W];

    // Encoded mode only counts when a controller is strapped present.
    // In that mode the lines come from same-clock logic and are read
    // raw: the synchroniser delays each bit alike but a raw read keeps
    // the acknowledge tied to the value the controller still knows.
    assign eic_mode  = (INT_MODE_I == CIP_MODE_EIC) && r_q.cap_eic;
    assign lines_use = eic_mode ? LINK.int_lines : lines_sync;

    // Active-high levels; no latching, a dropped line is no request.
    assign lines_masked = lines_use & INT_MASK_I;

    // A request counts when it beats the current level (encoded) or
    // when any enabled line is high (the other two modes).
    always_comb begin
        if (eic_mode) begin
            req_pending = (lines_use > STATUS_IPL_I);
        end else begin
            req_pending = |lines_masked;
        end
    end

    // Vector choice per mode.  Compatibility mode treats all six lines
    // alike and hands the pipeline no vector at all.
    always_comb begin
        case (INT_MODE_I)
            CIP_MODE_COMPAT: begin
                vec_sel = `CIP_PRIO_RST;
            end
            CIP_MODE_VECTOR: begin
                vec_sel = cip_highest(`CIP_MAX_SRC'(lines_masked));
            end
            CIP_MODE_EIC: begin
                vec_sel = eic_mode ? lines_use : `CIP_PRIO_RST;
            end
            default: begin
                vec_sel = `CIP_PRIO_RST;
            end
        endcase
    end

    // Next-state logic for all of the end's state.
    always_comb begin
        r_d       = r_q;
        r_d.ack   = 1'b0;
        r_d.taken = 1'b0;

        // The strap is static; reading it every cycle costs nothing.
        r_d.cap_eic = strap_sync;

        // Software writes of the status word carry the power bit.
        if (STATUS_WE_I) begin
            r_d.rp = STATUS_WDATA_I[`CIP_STATUS_RP];
        end

        case (r_q.st)
            CIP_ST_RUN: begin
                // A pending enabled interrupt beats an idle-halt in the same
                // cycle, so an enabled core never sleeps on a ready request.
                if (req_pending && INT_ENABLE_I) begin
                    r_d.st     = CIP_ST_HANDLER;
                    r_d.busy   = 1'b1;
                    r_d.taken  = 1'b1;
                    r_d.ripl   = lines_use;
                    r_d.vector = vec_sel;
                    if (eic_mode) begin
                        r_d.ack    = 1'b1;
                        r_d.ipl    = STATUS_IPL_I;
                        r_d.shadow = LINK.shadow_set_select_in;
                    end else begin
                        r_d.shadow = `CIP_SS_RST;
                    end
                end else if (WAIT_EXEC_I) begin
                    r_d.st    = CIP_ST_SLEEP;
                    r_d.sleep = 1'b1;
                end
            end
            CIP_ST_SLEEP: begin
                // Nothing but a pending request is watched here; the
                // pipeline clock is held by whoever sees the indication.
                if (req_pending) begin
                    r_d.st    = CIP_ST_RUN;
                    r_d.sleep = 1'b0;
                end else begin
                    r_d.sleep = 1'b1;
                end
            end
            CIP_ST_HANDLER: begin
                // One interrupt at a time; the return frees the core.
                if (ERET_I) begin
                    r_d.st   = CIP_ST_RUN;
                    r_d.busy = 1'b0;
                end
            end
            default: begin
                r_d.st    = CIP_ST_RUN;
                r_d.busy  = 1'b0;
                r_d.sleep = 1'b0;
            end
        endcase
    end

    // One register for the whole state.
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // Every output is a flip-flop of the state.
    assign LINK.interrupt_ack_pulse    = r_q.ack;
    assign LINK.current_priority_out   = r_q.ipl;
    assign LINK.reduced_power_hint_out = r_q.rp;
    assign LINK.sleep_ind              = r_q.sleep;
    assign INT_TAKEN_O                 = r_q.taken;
    assign IN_HANDLER_O                = r_q.busy;
    assign SLEEP_O                     = r_q.sleep;
    assign CAP_EIC_O                   = r_q.cap_eic;
    assign RIPL_O                      = r_q.ripl;
    assign VECTOR_O                    = r_q.vector;
    assign SHADOW_SET_O                = r_q.shadow;

endmodule

/* rtl/cip_ctrl_end.sv */
// Controller end: prioritises request sources, presents the encoded
// vector and shadow set, retires a source when the core acknowledges.
// Assumes the core end shares SYS_CLK_I; sources are same-clock logic.
`timescale 1ns/1ns
`include "cip_regs.svh"

module cip_ctrl_end #(
    parameter int NUM_SRC = `CIP_MAX_SRC
) (
    // Clock and reset.
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   SRST_I,
    // Link to the core.
    cip_if.ctrl                         LINK,
    // Request sources; source i carries vector i+1.
    input  wire logic [NUM_SRC-1:0]     SRC_REQ_I,
    input  wire logic [NUM_SRC-1:0]     SRC_DONE_I,
    input  wire logic [`CIP_SS_W-1:0]   SHADOW_SET_I,
    // Status for the system.
    output logic [NUM_SRC-1:0]          IN_SERVICE_O,
    output logic [`CIP_INT_W-1:0]       PRESENTED_O,
    output logic [`CIP_INT_W-1:0]       CORE_IPL_O
);
    import cip_pkg::*;

    cip_ctrl_reg_t           r_q;
    cip_ctrl_reg_t           r_d;
    logic [`CIP_MAX_SRC-1:0] cand;

    // Vectors must fit the six encoded lines.
    initial begin
        if (NUM_SRC < 1 || NUM_SRC > `CIP_MAX_SRC) begin
            $error("cip_ctrl_end supports 1 to 63 sources");
        end
    end

    // Sources already in service are held back so the next one shows.
    assign cand = `CIP_MAX_SRC'(SRC_REQ_I & ~r_q.in_service[NUM_SRC-1:0]);

    always_comb begin
        r_d        = r_q;
        r_d.strap  = `CIP_STRAP_ON;
        r_d.last   = r_q.lines;
        r_d.ipl    = LINK.current_priority_out;
        // Registered, so all six bits change on one clock edge.
        r_d.lines  = cip_highest(cand);
        r_d.shadow = SHADOW_SET_I;
        // Clear first so a same-cycle acknowledge wins.
        r_d.in_service = r_q.in_service & ~`CIP_MAX_SRC'(SRC_DONE_I);
        // The core sampled the value shown one cycle before the pulse.
        if (LINK.interrupt_ack_pulse && r_q.last != `CIP_PRIO_RST) begin
            r_d.in_service[r_q.last - 1'b1] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign LINK.int_lines                    = r_q.lines;
    assign LINK.shadow_set_select_in         = r_q.shadow;
    assign LINK.ext_controller_present_strap = r_q.strap;
    assign IN_SERVICE_O                      = r_q.in_service[NUM_SRC-1:0];
    assign PRESENTED_O                       = r_q.lines;
    assign CORE_IPL_O                        = r_q.ipl;

endmodule

/* bench/cip_link_asserts.sv */
// Concurrent checks on the link between the core end and controller end.
// Assumes it sits beside the cip_if instance of the bench, one clock.
`timescale 1ns/1ns
`include "cip_regs.svh"

module cip_link_asserts (
    // Clock and reset.
    input wire logic                  SYS_CLK_I,
    input wire logic                  SRST_I,
    // Link signals, only watched.
    input wire logic [`CIP_INT_W-1:0] int_lines,
    input wire logic                  ext_controller_present_strap,
    input wire logic                  interrupt_ack_pulse,
    input wire logic [`CIP_INT_W-1:0] current_priority_out,
    input wire logic                  sleep_ind
);
    // One domain, so clock and reset are named once for every check.
    default clocking dc @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SRST_I);

    // The acknowledge is a single-cycle pulse.
    ack_single_cycle_a: assert property (
        interrupt_ack_pulse |=> !interrupt_ack_pulse)
        else $error("acknowledge held longer than one cycle");

    // The priority output moves only together with the acknowledge.
    ipl_hold_a: assert property (
        !$stable(current_priority_out) |-> interrupt_ack_pulse)
        else $error("priority output changed without acknowledge");

    // A take needs a vector above the priority level in force.
    take_above_ipl_a: assert property (
        interrupt_ack_pulse |-> $past(int_lines) > current_priority_out)
        else $error("acknowledge for a vector not above the level");

    // The strap stands high from the second edge after reset.
    strap_on_a: assert property (
        !$past(SRST_I) |-> ext_controller_present_strap)
        else $error("presence strap low outside reset");

    // An acknowledged vector is retired from the lines two cycles on.
    ack_retire_a: assert property (
        interrupt_ack_pulse |-> ##2 int_lines != $past(int_lines, 3))
        else $error("acknowledged vector still presented");

    // No take is acknowledged while the core is asleep.
    sleep_no_ack_a: assert property (
        sleep_ind |-> !interrupt_ack_pulse)
        else $error("acknowledge while asleep");

    // Sleep is entered from running code, never in the acknowledge cycle.
    sleep_entry_a: assert property (
        $rose(sleep_ind) |-> !$past(interrupt_ack_pulse))
        else $error("sleep entered straight after a take");

    // A presented request ends sleep within a few cycles.
    wake_bound_a: assert property (
        sleep_ind && int_lines != 6'h00 |-> ##[1:4] !sleep_ind)
        else $error("sleep not left after a request");
endmodule

/* bench/core_interrupt_power_signals_test.sv */
// Self-checking bench: both link ends joined, user sides driven here.
// Assumes the rtl files and cip_regs.svh are compiled before it.
`timescale 1ns/1ns
`include "cip_regs.svh"

module core_interrupt_power_signals_test;
    import cip_pkg::*;

    `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
        n_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end

    logic        sys_clk  = 1'b0;
    logic        srst     = 1'b1;
    logic        st_we    = 1'b0;
    logic [31:0] st_wdata = 32'h0;
    logic [5:0]  st_ipl   = 6'h00;
    logic        int_en   = 1'b0;
    logic [5:0]  int_mask = 6'h3f;
    cip_mode_t   mode     = CIP_MODE_EIC;
    logic        wait_ex  = 1'b0;
    logic        eret     = 1'b0;
    logic [62:0] src_req  = '0;
    logic [62:0] src_done = '0;
    logic [3:0]  ss_in    = 4'h0;
    logic        taken;
    logic        in_hdl;
    logic        sleep;
    logic        cap_eic;
    logic [5:0]  ripl;
    logic [5:0]  vec;
    logic [3:0]  shadow;
    logic [62:0] in_svc;
    logic [5:0]  presented;
    logic        hint;
    logic [5:0]  core_ipl;
    bit   [62:0] ins_m;
    int          n_errors;
    int          cmp_count;
    int          a;
    int          b;

    cip_if link();

    // Short name for the power hint so checks fit on one line.
    assign hint = link.reduced_power_hint_out;

    cip_core_end u_cip_core_end (
        .SYS_CLK_I(sys_clk), .SRST_I(srst), .LINK(link),
        .STATUS_WE_I(st_we), .STATUS_WDATA_I(st_wdata),
        .STATUS_IPL_I(st_ipl), .INT_ENABLE_I(int_en),
        .INT_MASK_I(int_mask), .INT_MODE_I(mode), .WAIT_EXEC_I(wait_ex),
        .ERET_I(eret), .INT_TAKEN_O(taken), .IN_HANDLER_O(in_hdl),
        .SLEEP_O(sleep), .CAP_EIC_O(cap_eic), .RIPL_O(ripl),
        .VECTOR_O(vec), .SHADOW_SET_O(shadow));

    cip_ctrl_end u_cip_ctrl_end (
        .SYS_CLK_I(sys_clk), .SRST_I(srst), .LINK(link),
        .SRC_REQ_I(src_req), .SRC_DONE_I(src_done), .SHADOW_SET_I(ss_in),
        .IN_SERVICE_O(in_svc), .PRESENTED_O(presented),
        .CORE_IPL_O(core_ipl));

    cip_link_asserts u_cip_link_asserts (
        .SYS_CLK_I(sys_clk), .SRST_I(srst), .int_lines(link.int_lines),
        .ext_controller_present_strap(link.ext_controller_present_strap),
        .interrupt_ack_pulse(link.interrupt_ack_pulse),
        .current_priority_out(link.current_priority_out),
        .sleep_ind(link.sleep_ind));

    // Free-running clock, 40 ns period.
    always #20 sys_clk = ~sys_clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Model: highest set bit plus one, which is both the controller's
    // priority choice and the vectored-mode vector.
    function automatic int model_vec(input logic [62:0] r);
        int v;
        v = 0;
        for (int i = 0; i < 63; i++) begin
            if (r[i] === 1'b1) begin
                v = i + 1;
            end
        end
        return v;
    endfunction

    // Bounded wait for a take, then compare what was captured with it.
    task automatic expect_take(input int v, input int vx, input int ss,
                               input logic ack);
        int k;
        k = 0;
        while (taken !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        `CHK("taken", 1'b1, taken)
        `CHK("ripl", 6'(v), ripl)
        `CHK("vector", 6'(vx), vec)
        `CHK("shadow", 4'(ss), shadow)
        `CHK("presented", 6'(v), presented)
        `CHK("ack", ack, link.interrupt_ack_pulse)
        if (ack) `CHK("ipl", st_ipl, link.current_priority_out)
        cyc(1);
        `CHK("ack end", 1'b0, link.interrupt_ack_pulse)
        `CHK("handler", 1'b1, in_hdl)
        if (ack) `CHK("in service", 1'b1, in_svc[v-1])
        if (ack) `CHK("core ipl", st_ipl, core_ipl)
    endtask

    // A handler in progress, or a disabled core, refuses every take.
    task automatic no_take(input int n);
        repeat (n) begin
            cyc(1);
            `CHK("no take", 1'b0, taken)
        end
    endtask

    // Source retires its request, then the handler returns.  The return
    // waits for the synchroniser to drain so a stale level is not taken
    // again, and it ends just after the return edge, before the next
    // take can be missed.
    task automatic finish_isr(input int i);
        src_req[i] = 1'b0;
        src_done[i] = 1'b1;
        cyc(1);
        src_done[i] = 1'b0;
        ins_m[i] = 1'b0;
        `CHK("in service end", 1'b0, in_svc[i])
        cyc(2);
        eret = 1'b1;
        cyc(1);
        eret = 1'b0;
        `CHK("handler end", 1'b0, in_hdl)
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog, 5000 cycles, far beyond the hundred or so cycles the tests need.
    initial begin
        #(40 * 5000);
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hebbf3968));
        cyc(4);
        `CHK("sleep rst", 1'b0, sleep)
        srst = 1'b0;
        cyc(4);
        `CHK("cap", 1'b1, cap_eic)
        // Hint follows the power bit of each write and holds between.
        repeat (4) begin
            st_wdata = $urandom;
            st_we = 1'b1;
            cyc(1);
            st_we = 1'b0;
            `CHK("hint", st_wdata[`CIP_STATUS_RP], hint)
            cyc(1);
            `CHK("hint", st_wdata[`CIP_STATUS_RP], hint)
        end
        // Top vector: refused while disabled, refused at the top level,
        // then taken.
        ss_in = 4'($urandom);
        st_ipl = 6'h3e;
        src_req[62] = 1'b1;
        no_take(3);
        int_en = 1'b1;
        st_ipl = 6'h3f;
        no_take(3);
        st_ipl = 6'h3e;
        expect_take(63, 63, ss_in, 1'b1);
        ins_m[62] = 1'b1;
        finish_isr(62);
        // Two sources: the higher first, the lower after return.
        a = $urandom_range(30, 0);
        b = $urandom_range(61, 31);
        st_ipl = 6'($urandom_range(a, 0));
        src_req[a] = 1'b1;
        src_req[b] = 1'b1;
        expect_take(model_vec(src_req & ~ins_m), b + 1, ss_in, 1'b1);
        ins_m[b] = 1'b1;
        no_take(4);
        st_ipl = 6'($urandom_range(a, 0));
        finish_isr(b);
        expect_take(model_vec(src_req & ~ins_m), a + 1, ss_in, 1'b1);
        finish_isr(a);
        // Sleep until a request arrives, even with level zero.
        st_ipl = 6'h00;
        wait_ex = 1'b1;
        cyc(1);
        wait_ex = 1'b0;
        `CHK("sleep", 1'b1, link.sleep_ind)
        cyc(5);
        `CHK("asleep", 1'b1, sleep)
        a = $urandom_range(62, 0);
        src_req[a] = 1'b1;
        b = 0;
        while (sleep !== 1'b0 && b < 8) begin
            cyc(1);
            b++;
        end
        `CHK("awake", 1'b0, sleep)
        expect_take(a + 1, a + 1, ss_in, 1'b1);
        finish_isr(a);
        // Compatibility and vectored modes: synchronised, no acknowledge.
        for (int m = 0; m < 2; m++) begin
            mode = cip_mode_t'(m);
            a = $urandom_range(62, 0);
            int_mask = 6'($urandom);
            if ((int_mask & 6'(a + 1)) == 6'h00) begin
                int_mask = 6'h3f;
            end
            src_req[a] = 1'b1;
            b = m ? model_vec(63'(int_mask & 6'(a + 1))) : 0;
            expect_take(a + 1, b, 0, 1'b0);
            src_req[a] = 1'b0;
            cyc(6);
            finish_isr(a);
        end
        print_verdict();
    end
endmodule
